//--- src/wdu_top.sv
// watchdog downcounter, reload unlock sequence and reset/stop status flags
// assumes cpu register strobes synchronous to clk_sys_i, one access per cycle;
// the rc oscillator is replaced by a divided enable pulse, so one clock only
`timescale 1ns/10ps
`include "wdu_params.svh"

// What this block does
// RULE1: counter steps only on the rc-rate tick, nominally 50 kHz
// RULE2: enabled by refresh or always-on option; no way back to off
// RULE3: 24-bit down-counter, reload is upper, high, low bytes
// RULE4: on first enable the counter loads the reload value
// RULE5: a refresh while count is above 000002H reloads the counter and counting resumes
// RULE6: refresh ignored once count has reached 000002H
// RULE7: software must keep reload at or above 000004H
// RULE8: time-out at zero; response option picks interrupt or short reset
// RULE9: interrupt response, not stopped: irq and time-out flag
// RULE10: after interrupt time-out counter wraps to all ones
// RULE11: interrupt response in stop: recovery, irq, both flags
// RULE12: reset response, not stopped: short reset and time-out flag
// RULE13: reset response in stop: recovery instead, both flags set
// RULE14: debug mode keeps refreshing so no time-out occurs
// RULE15: reload locked until 55H then AAH to control; control unchanged
// RULE16: software writes upper, high, low bytes in that order
// RULE17: any other write mid-sequence relocks the state machine
// RULE18: nominal period in ms is reload divided by 50
// RULE19: reading control clears its upper four flags
// RULE20: reload byte reads give live count; writes set reload
// RULE21: after low byte write the sequence returns to locked
module wdu_top (
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  input  wire logic [11:0]          reg_addr_i,
  input  wire logic [7:0]           reg_wdata_i,
  input  wire logic                 refresh_i,
  input  wire logic                 always_on_option_i,
  input  wire logic                 timeout_response_option_i,
  input  wire logic                 stop_mode_i,
  input  wire logic                 debug_mode_i,
  input  wire logic                 por_event_i,
  input  wire logic                 ext_reset_event_i,
  input  wire logic                 pin_recovery_i,
  output logic [7:0]                reg_rdata_o,
  output logic                      irq_o,
  output logic                      short_reset_o,
  output logic                      stop_recovery_o,
  output logic                      enabled_o,
  output logic [`WDU_CNT_W-1:0]     count_o
);
  // ------------------------------------------------------------
  // request decode
  // ------------------------------------------------------------
  wdu_pkg::wdu_reg_req_t req;
  assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i, wdata: reg_wdata_i};

  wire hit_ctl = (req.addr == `WDU_ADDR_CTL);
  wire hit_u   = (req.addr == `WDU_ADDR_U);
  wire hit_h   = (req.addr == `WDU_ADDR_H);
  wire hit_l   = (req.addr == `WDU_ADDR_L);

  wire rc_tick;
  wdu_rc_tick u_tick (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .tick_o    (rc_tick)
  );

  // ------------------------------------------------------------
  // unlock state machine
  // ------------------------------------------------------------
  wdu_pkg::wdu_lock_t lock_q;
  wdu_pkg::wdu_lock_t lock_d;

  always_comb begin
    lock_d = lock_q;
    if (req.wr) begin
      case (lock_q)
        wdu_pkg::WDU_LOCKED: lock_d = (hit_ctl && req.wdata == `WDU_UNLOCK_1) ?
                                      wdu_pkg::WDU_GOT_55 : wdu_pkg::WDU_LOCKED; // RULE15
        wdu_pkg::WDU_GOT_55: lock_d = (hit_ctl && req.wdata == `WDU_UNLOCK_2) ?
                                      wdu_pkg::WDU_OPEN_U : wdu_pkg::WDU_LOCKED; // RULE15 RULE17
        wdu_pkg::WDU_OPEN_U: lock_d = hit_u ? wdu_pkg::WDU_OPEN_H : wdu_pkg::WDU_LOCKED; // RULE17
        wdu_pkg::WDU_OPEN_H: lock_d = hit_h ? wdu_pkg::WDU_OPEN_L : wdu_pkg::WDU_LOCKED; // RULE17
        wdu_pkg::WDU_OPEN_L: lock_d = wdu_pkg::WDU_LOCKED; // RULE21
        default:             lock_d = wdu_pkg::WDU_LOCKED;
      endcase
    end
  end

  wire wr_u = req.wr && hit_u && (lock_q == wdu_pkg::WDU_OPEN_U);
  wire wr_h = req.wr && hit_h && (lock_q == wdu_pkg::WDU_OPEN_H);
  wire wr_l = req.wr && hit_l && (lock_q == wdu_pkg::WDU_OPEN_L);

  // ------------------------------------------------------------
  // reload value
  // ------------------------------------------------------------
  logic [7:0] rel_u_q;
  logic [7:0] rel_h_q;
  logic [7:0] rel_l_q;
  // reload below the minimum is the caller's fault and is not checked here
  wire [`WDU_CNT_W-1:0] reload_val = {rel_u_q, rel_h_q, rel_l_q}; // RULE3 RULE7

  // ------------------------------------------------------------
  // counter
  // ------------------------------------------------------------
  wire start       = !enabled_o && (refresh_i || always_on_option_i);           // RULE2
  wire refresh_ok  = enabled_o && (refresh_i || debug_mode_i) &&
                     (count_o > `WDU_CNT_NOREFRESH);                             // RULE5 RULE6 RULE14
  wire timeout     = enabled_o && !refresh_ok && rc_tick &&
                     (count_o == `WDU_CNT_ONE) && !debug_mode_i;                  // RULE8
  wire to_int      = timeout && !timeout_response_option_i;
  wire to_rst      = timeout && timeout_response_option_i;

  wire cnt_load    = start || refresh_ok;                                        // RULE4 RULE5
  wire cnt_step    = enabled_o && rc_tick;                                       // RULE1

  logic [`WDU_CNT_W-1:0] cnt_d;
  // period in ms = reload / 50 because the tick runs at the nominal rc rate
  assign cnt_d = cnt_load ? reload_val :                                        // RULE4 RULE5 RULE18
                 timeout  ? `WDU_CNT_MAX :                                      // RULE10
                 cnt_step ? count_o - `WDU_CNT_ONE :                            // RULE1
                 count_o;

  // ------------------------------------------------------------
  // status flags, set wins over read clear
  // ------------------------------------------------------------
  wire rd_ctl      = req.rd && hit_ctl;
  wire stop_to     = timeout && stop_mode_i;
  logic por_q;
  logic stop_q;
  logic to_q;
  logic ext_q;
  wdu_pkg::wdu_flags_t flag_set;
  assign flag_set = '{timeout_flag: timeout, stop_flag: stop_to};               // RULE9 RULE11 RULE12 RULE13

  wire por_d  = por_event_i ? 1'b1 :
                (timeout || pin_recovery_i || rd_ctl) ? 1'b0 : por_q;           // RULE19
  wire stop_d = (flag_set.stop_flag || pin_recovery_i) ? 1'b1 :
                (por_event_i || (timeout && !stop_mode_i) || rd_ctl) ? 1'b0 : stop_q; // RULE19
  wire to_d   = flag_set.timeout_flag ? 1'b1 :
                (por_event_i || pin_recovery_i || rd_ctl) ? 1'b0 : to_q;        // RULE19
  wire ext_d  = ext_reset_event_i ? 1'b1 :
                (por_event_i || pin_recovery_i || rd_ctl) ? 1'b0 : ext_q;       // RULE19

  // fixed field positions; reserved low nibble always reads zero
  logic [7:0] ctl_view;
  always_comb begin
    ctl_view                 = 8'h00;
    ctl_view[`WDU_FLAG_POR]  = por_q;
    ctl_view[`WDU_FLAG_STOP] = stop_q;
    ctl_view[`WDU_FLAG_TO]   = to_q;
    ctl_view[`WDU_FLAG_EXT]  = ext_q;
  end

  // ------------------------------------------------------------
  // read data select
  // ------------------------------------------------------------
  // byte reads show the live count, not the stored reload
  wire rd_u = req.rd && hit_u;
  wire rd_h = req.rd && hit_h;
  wire rd_l = req.rd && hit_l;

  wire [7:0] rdata_d = rd_ctl ? ctl_view :
                       rd_u   ? count_o[23:16] :                                // RULE20
                       rd_h   ? count_o[15:8] :                                 // RULE20
                       rd_l   ? count_o[7:0] :                                  // RULE20
                       8'h00;

  // ------------------------------------------------------------
  // next values
  // ------------------------------------------------------------
  wire [7:0] rel_u_d   = wr_u ? req.wdata : rel_u_q;                           // RULE20
  wire [7:0] rel_h_d   = wr_h ? req.wdata : rel_h_q;                           // RULE20
  wire [7:0] rel_l_d   = wr_l ? req.wdata : rel_l_q;                           // RULE20
  wire       enabled_d = enabled_o || start;                                   // RULE2
  // short reset only outside stop; in stop both responses give recovery, and the interrupt response still raises irq
  wire       irq_d     = to_int;                                               // RULE9 RULE11
  wire       srst_d    = to_rst && !stop_mode_i;                               // RULE12
  wire       rec_d     = stop_to;                                              // RULE11 RULE13

  // ------------------------------------------------------------
  // lock and reload registers
  // ------------------------------------------------------------
  // a low-byte write always relocks, so every reload change needs a fresh unlock
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      lock_q <= wdu_pkg::WDU_LOCKED;
    end else begin
      lock_q <= lock_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rel_u_q <= 8'(`WDU_RELOAD_RST >> 16);
    end else begin
      rel_u_q <= rel_u_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rel_h_q <= 8'(`WDU_RELOAD_RST >> 8);
    end else begin
      rel_h_q <= rel_h_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rel_l_q <= 8'(`WDU_RELOAD_RST);
    end else begin
      rel_l_q <= rel_l_d;
    end
  end

  // ------------------------------------------------------------
  // counter registers
  // ------------------------------------------------------------
  // enable has no clear path other than chip reset
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      enabled_o <= 1'b0;
    end else begin
      enabled_o <= enabled_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      count_o <= `WDU_RELOAD_RST;
    end else begin
      count_o <= cnt_d;
    end
  end

  // ------------------------------------------------------------
  // status flag registers
  // ------------------------------------------------------------
  // set terms win over a same-cycle read clear, so no event is lost
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      por_q <= 1'b1;
    end else begin
      por_q <= por_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      stop_q <= 1'b0;
    end else begin
      stop_q <= stop_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      to_q <= 1'b0;
    end else begin
      to_q <= to_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= ext_d;
    end
  end

  // ------------------------------------------------------------
  // event outputs and read data
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      short_reset_o <= 1'b0;
    end else begin
      short_reset_o <= srst_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      stop_recovery_o <= 1'b0;
    end else begin
      stop_recovery_o <= rec_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= rdata_d;
    end
  end
endmodule : wdu_top

//--- src/wdu_params.svh
// constants for the watchdog downcounter with unlocked reload
// assumes one 40 MHz system clock; the rc oscillator is modelled as an enable pulse
`ifndef WDU_PARAMS_SVH
`define WDU_PARAMS_SVH

`define WDU_CLK_HZ        40000000
`define WDU_RC_HZ         50000
`define WDU_RC_DIV        (`WDU_CLK_HZ / `WDU_RC_HZ)
`define WDU_DIV_W         10
`define WDU_CNT_W         24
`define WDU_RELOAD_RST    24'hffffff
`define WDU_CNT_MAX       24'hffffff
`define WDU_CNT_NOREFRESH 24'h000002
`define WDU_CNT_ONE       24'h000001
`define WDU_CNT_ZERO      24'h000000
`define WDU_MIN_RELOAD    24'h000004
`define WDU_MS_DIVISOR    50
`define WDU_UNLOCK_1      8'h55
`define WDU_UNLOCK_2      8'haa
`define WDU_ADDR_CTL      12'hff0
`define WDU_ADDR_U        12'hff1
`define WDU_ADDR_H        12'hff2
`define WDU_ADDR_L        12'hff3
`define WDU_FLAG_POR      7
`define WDU_FLAG_STOP     6
`define WDU_FLAG_TO       5
`define WDU_FLAG_EXT      4

`endif

//--- src/wdu_pkg.sv
// types for the watchdog downcounter with unlocked reload
// assumes wdu_params.svh supplies the widths
`include "wdu_params.svh"
package wdu_pkg;
  typedef enum logic [2:0] {
    WDU_LOCKED,
    WDU_GOT_55,
    WDU_OPEN_U,
    WDU_OPEN_H,
    WDU_OPEN_L
  } wdu_lock_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } wdu_reg_req_t;

  typedef struct packed {
    logic timeout_flag;
    logic stop_flag;
  } wdu_flags_t;
endpackage : wdu_pkg

//--- src/wdu_rc_tick.sv
// divider making the watchdog rc-rate enable pulse
// assumes a free running system clock; one-cycle pulse per rc period
`timescale 1ns/10ps
`include "wdu_params.svh"
module wdu_rc_tick (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  output logic      tick_o
);
  logic [`WDU_DIV_W-1:0] div_q;
  logic [`WDU_DIV_W-1:0] div_d;
  wire                   wrap = (div_q == `WDU_DIV_W'(`WDU_RC_DIV - 1));

  assign div_d = wrap ? '0 : div_q + `WDU_DIV_W'(1);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      div_q  <= '0;
      tick_o <= 1'b0;
    end else begin
      div_q  <= div_d;
      tick_o <= wrap;
    end
  end
endmodule : wdu_rc_tick

//--- verif/wdu_top_props.sv
// port assertions for the watchdog downcounter
// assumes the wdu_top port list; bound to every wdu_top instance
`timescale 1ns/10ps
`include "wdu_params.svh"
module wdu_top_props (
  input wire logic                  clk_sys_i,
  input wire logic                  rst_i,
  input wire logic                  refresh_i,
  input wire logic                  timeout_response_option_i,
  input wire logic                  stop_mode_i,
  input wire logic                  debug_mode_i,
  input wire logic                  irq_o,
  input wire logic                  short_reset_o,
  input wire logic                  stop_recovery_o,
  input wire logic                  enabled_o,
  input wire logic [`WDU_CNT_W-1:0] count_o
);
  // -------
  // checks
  // -------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  wire logic any_to = irq_o | short_reset_o | stop_recovery_o;
  sequence s_last_step;
    count_o == 24'h000001 ##1 count_o == 24'hffffff;
  endsequence
  sequence s_late_kick;
    count_o == 24'h000002 && refresh_i;
  endsequence
  a_timeout_at_zero: assert property (s_last_step |-> any_to)
    else $error("no time-out pulse at wrap");
  a_wrap_to_max: assert property (any_to |-> count_o == 24'hffffff)
    else $error("count not at max after time-out");
  a_late_kick_ignored: assert property (s_late_kick |=> count_o inside {24'h000001, 24'h000002})
    else $error("refresh honoured at two");
  a_enable_sticky: assert property (enabled_o |=> enabled_o)
    else $error("watchdog turned off");
  a_irq_response: assert property (irq_o |-> !$past(timeout_response_option_i))
    else $error("interrupt in reset response");
  a_irq_single: assert property (irq_o |=> !irq_o)
    else $error("interrupt pulse too long");
  a_reset_response: assert property (short_reset_o |-> $past(timeout_response_option_i) && !$past(stop_mode_i))
    else $error("short reset out of place");
  a_stop_recovery: assert property (stop_recovery_o |-> $past(stop_mode_i))
    else $error("recovery outside stop mode");
  a_debug_quiet: assert property (debug_mode_i && $past(debug_mode_i) |-> !any_to)
    else $error("time-out in debug mode");
endmodule : wdu_top_props
bind wdu_top wdu_top_props u_props (.clk_sys_i, .rst_i, .refresh_i, .timeout_response_option_i, .stop_mode_i,
  .debug_mode_i, .irq_o, .short_reset_o, .stop_recovery_o, .enabled_o, .count_o);

//--- verif/wdu_cpu_model.sv
// stand-in for the cpu interrupt controller and reset logic
// assumes one-cycle registered event pulses from wdu_top
`timescale 1ns/10ps
module wdu_cpu_model (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       irq_i,
  input  wire logic       short_reset_i,
  input  wire logic       stop_recovery_i,
  output logic      [7:0] n_irq_o,
  output logic      [7:0] n_rst_o,
  output logic      [7:0] n_rec_o
);
  // ---------------
  // event counters
  // ---------------
  // counts rather than resets the chip, so repeated pulses stay visible
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      {n_irq_o, n_rst_o, n_rec_o} <= 24'h000000;
    end else begin
      n_irq_o <= n_irq_o + 8'(irq_i);
      n_rst_o <= n_rst_o + 8'(short_reset_i);
      n_rec_o <= n_rec_o + 8'(stop_recovery_i);
    end
  end
endmodule : wdu_cpu_model

//--- verif/test_wdu_top.sv
// self-checking bench for the watchdog downcounter
// assumes wdu_top, wdu_cpu_model and the bound checker compiled beforehand
`timescale 1ns/10ps
`include "wdu_params.svh"
module test_wdu_top;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, kick = 1'b0, irq, srst, rec, en;
  logic        ao = 1'b0, opt = 1'b0, stop = 1'b0, dbg = 1'b0;
  logic [2:0]  ev = 3'h0;
  logic [11:0] addr = 12'h000;
  logic [7:0]  wdata = 8'h00, rdata, n_irq, n_rst, n_rec, e_irq = 8'h00, e_rst = 8'h00, e_rec = 8'h00;
  logic [23:0] cnt;
  int          n_errors = 0, compares = 0, i, k;
  initial forever #12.5 clk = ~clk;
  wdu_top dut (.clk_sys_i(clk), .rst_i(rst), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .refresh_i(kick), .always_on_option_i(ao), .timeout_response_option_i(opt), .stop_mode_i(stop),
    .debug_mode_i(dbg), .por_event_i(ev[2]), .ext_reset_event_i(ev[1]), .pin_recovery_i(ev[0]),
    .reg_rdata_o(rdata), .irq_o(irq), .short_reset_o(srst), .stop_recovery_o(rec), .enabled_o(en), .count_o(cnt));
  wdu_cpu_model u_cpu (.clk_sys_i(clk), .rst_i(rst), .irq_i(irq), .short_reset_i(srst), .stop_recovery_i(rec),
    .n_irq_o(n_irq), .n_rst_o(n_rst), .n_rec_o(n_rec));
  // -------------
  // access tasks
  // -------------
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    {wr, addr, wdata} = {1'b1, a, d};
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    @(negedge clk);
    {rd, addr} = {1'b1, a};
    @(negedge clk);
    rd = 1'b0;
    chk(rdata, e);
  endtask : rd_chk
  task automatic kick_once;
    @(negedge clk);
    kick = 1'b1;
    @(negedge clk);
    kick = 1'b0;
  endtask : kick_once
  // bounded wait for count two or for any time-out pulse
  task automatic wait_until(input bit on_ev, input int bound);
    for (k = 0; k < bound; k++) begin
      @(negedge clk);
      if (on_ev ? (irq | srst | rec) === 1'b1 : cnt === 24'h000002) break;
    end
    if (k == bound) begin
      n_errors++;
      report_and_stop();
    end
  endtask : wait_until
  task automatic report_and_stop;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  // ---------
  // sequence
  // ---------
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    chk(cnt, `WDU_RELOAD_RST);
    chk(en, 1'b0);
    rd_chk(`WDU_ADDR_CTL, 8'h80);
    for (i = 0; i < 3; i++) begin
      @(negedge clk);
      ev = 3'h1 << i;
      @(negedge clk);
      ev = 3'h0;
      rd_chk(`WDU_ADDR_CTL, i == 0 ? 8'h40 : i == 1 ? 8'h10 : 8'h80);
    end
    wr_reg(`WDU_ADDR_L, 8'h04);
    kick_once();
    @(negedge clk);
    chk(en, 1'b1);
    chk(cnt, `WDU_RELOAD_RST);
    rd_chk(`WDU_ADDR_U, 8'hff);
    rd_chk(`WDU_ADDR_H, 8'hff);
    // broken sequence: a stray write must relock
    wr_reg(`WDU_ADDR_CTL, `WDU_UNLOCK_1);
    wr_reg(`WDU_ADDR_CTL, `WDU_UNLOCK_2);
    wr_reg(`WDU_ADDR_U, 8'h00);
    wr_reg(12'h100, 8'h00);
    wr_reg(`WDU_ADDR_H, 8'h00);
    wr_reg(`WDU_ADDR_L, 8'h08);
    kick_once();
    // upper byte was taken before the stray write; high and low stay blocked
    chk(cnt, 24'h00ffff);
    wr_reg(`WDU_ADDR_CTL, `WDU_UNLOCK_1);
    wr_reg(`WDU_ADDR_CTL, `WDU_UNLOCK_2);
    wr_reg(`WDU_ADDR_U, 8'h00);
    wr_reg(`WDU_ADDR_H, 8'h00);
    wr_reg(`WDU_ADDR_L, 8'h08);
    rd_chk(`WDU_ADDR_CTL, 8'h00);
    wr_reg(`WDU_ADDR_L, 8'h05);
    kick_once();
    chk(cnt, 24'h000008);
    rd_chk(`WDU_ADDR_L, 8'h08);
    for (i = 0; i < 4; i++) begin
      {stop, opt} = 2'(i);
      kick_once();
      wait_until(1'b0, 5000);
      chk(k >= 3990 && k <= 4810, 1'b1);
      kick_once();
      wait_until(1'b1, 1700);
      {e_irq, e_rst, e_rec} = {e_irq + 8'(!opt), e_rst + 8'(opt & !stop), e_rec + 8'(stop)};
      repeat (2) @(negedge clk);
      chk(cnt, `WDU_CNT_MAX);
      chk({n_irq, n_rst, n_rec}, {e_irq, e_rst, e_rec});
      rd_chk(`WDU_ADDR_CTL, stop ? 8'h60 : 8'h20);
    end
    {stop, opt, dbg} = 3'h1;
    kick_once();
    repeat (12 * `WDU_RC_DIV) @(negedge clk);
    chk({n_irq, n_rst, n_rec}, {e_irq, e_rst, e_rec});
    chk(cnt, 24'h000008);
    {dbg, ao, rst} = 3'h3;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk(en, 1'b1);
    chk(cnt, `WDU_RELOAD_RST);
    report_and_stop();
  end
endmodule : test_wdu_top
